// ### core/rpm_access_port.sv
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "rpm_defs.svh"
// Behaviour
// - Load-done bit 21 reads one after the serial ROM load finishes; zero after reset.
// - Writing one to bit 20 restarts the automatic serial ROM load.
// - Bit 19 reads the synchronised MDIO input level.
// - Bit 18 selects management direction; set means the port drives MDIO.
// - Bit 17 is driven onto MDIO as output data.
// - Bit 16 is driven onto the MDC pin.
// - Bit 14 starts a read of the boot ROM; it needs bit 12 set and bit 11 clear.
// - Bit 13 starts a write; boot ROM writes need multiplexed mode.
// - Bit 12, one after reset, routes the memory interface to the boot ROM.
// - Bit 11, zero after reset, selects serial ROM; bits 3:0 become its pins.
// - Bit 10, one after reset, selects an external register.
// - In boot ROM mode bits 7:0 hold the byte read or to be written.
// - In serial ROM mode bit 3 reads the serial ROM data output pin.
// - In serial ROM mode bit 2 drives the serial ROM data input pin.
// - In serial ROM mode bit 1 drives the serial ROM clock pin.
// - In serial ROM mode bit 0 drives the serial ROM chip select pin.
// - Address pointer bits 17:0 address the boot ROM in register access.
module rpm_access_port #(
  parameter int ADDR_W = 18,
  parameter int ROM_WAIT = 4,
  parameter int LOAD_HALF = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  input wire logic MUX_MODE,
  output logic MDC,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE,
  output logic SROM_CS,
  output logic SROM_CLK,
  output logic SROM_DI,
  input wire logic SROM_DO,
  output logic [ADDR_W-1:0] BROM_ADDR,
  output logic BROM_CE_N,
  output logic BROM_OE_N,
  output logic BROM_WE_N,
  output logic XREG_SEL,
  input wire logic [7:0] BROM_DATA_I,
  output logic [7:0] BROM_DATA_O,
  output logic BROM_DATA_OE,
  output logic [15:0] LOAD_WORD,
  output logic LOAD_WORD_VALID
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic load_done, mdir, mgmt_data_out_drive, mdc, brom, srom, xreg;
  logic mrd, mwr;
  logic [7:0] data;
  logic [ADDR_W-1:0] addr_ptr;
  logic [`RPM_IRQ_W-1:0] irq_status, irq_mask, irq_set;
  logic mdio_s1, mdio_s2, sdo_s1, sdo_s2;
  logic mux_s1, mux_s2;
  logic [7:0] bd_s1, bd_s2;
  rpm_pkg::rpm_state_t state;
  logic [7:0] cnt;
  logic [4:0] bitn;
  logic [4:0] word;
  logic [15:0] shreg;
  logic ld_cs, ld_clk;
  logic reload_req;
  wire wr_acc = WR && (ADDR == `RPM_OFF_ACCESS);
  wire idle = (state == rpm_pkg::RPM_IDLE);
  // Boot ROM cycles start only from an idle sequencer with the boot ROM routed.
  wire rom_rd_go = wr_acc && brom && !srom && WDATA[`RPM_BIT_MRD];
  wire rom_wr_go = wr_acc && brom && !srom && WDATA[`RPM_BIT_MWR] && mux_s2;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // The multiplexed-mode strap is a pin too and takes the same two stages.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mdio_s1 <= 1'b0;
      mdio_s2 <= 1'b0;
      sdo_s1 <= 1'b0;
      sdo_s2 <= 1'b0;
      bd_s1 <= 8'h00;
      bd_s2 <= 8'h00;
      mux_s1 <= 1'b0;
      mux_s2 <= 1'b0;
    end else begin
      mdio_s1 <= MDIO_I;
      mdio_s2 <= mdio_s1;
      sdo_s1 <= SROM_DO;
      sdo_s2 <= sdo_s1;
      bd_s1 <= BROM_DATA_I;
      bd_s2 <= bd_s1;
      mux_s1 <= MUX_MODE;
      mux_s2 <= mux_s1;
    end
  end

  // ----------------------------------------------------------------
  // Access register fields
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mdir <= 1'b0;
      mgmt_data_out_drive <= 1'b0;
      mdc <= 1'b0;
      brom <= `RPM_RST_BROM;
      srom <= `RPM_RST_SROM;
      xreg <= `RPM_RST_XREG;
    end else if (wr_acc) begin
      mdir <= WDATA[`RPM_BIT_MDIR];
      mgmt_data_out_drive <= WDATA[`RPM_BIT_MGMT_DATA_OUT_DRIVE];
      mdc <= WDATA[`RPM_BIT_MDC];
      brom <= WDATA[`RPM_BIT_BROM];
      srom <= WDATA[`RPM_BIT_SROM];
      xreg <= WDATA[`RPM_BIT_XREG];
    end
  end

  // Data byte: written by software, or loaded by a completed boot ROM read.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      data <= `RPM_RST_DATA;
    end else if (state == rpm_pkg::RPM_ROM_RD && cnt == 8'h00) begin
      data <= bd_s2;
    end else if (wr_acc) begin
      data <= WDATA[7:0];
    end
  end

  // The pointer has no defined reset value; zero is used here.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_ptr <= '0;
    end else if (WR && ADDR == `RPM_OFF_ADDRPTR) begin
      addr_ptr <= WDATA[ADDR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: serial ROM auto load and boot ROM cycles
  // ----------------------------------------------------------------
  // Read and write triggers read back as one until the cycle finishes.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= rpm_pkg::RPM_LD_CS;
      cnt <= 8'h00;
      bitn <= 5'h00;
      word <= 5'h00;
      shreg <= 16'h0000;
      ld_cs <= 1'b0;
      ld_clk <= 1'b0;
      mrd <= 1'b0;
      mwr <= 1'b0;
      reload_req <= 1'b0;
    end else begin
      if (wr_acc && WDATA[`RPM_BIT_RELOAD]) begin
        reload_req <= 1'b1;
      end
      case (state)
        rpm_pkg::RPM_IDLE: begin
          if (reload_req) begin
            reload_req <= 1'b0;
            word <= 5'h00;
            state <= rpm_pkg::RPM_LD_CS;
          end else if (rom_rd_go) begin
            mrd <= 1'b1;
            cnt <= 8'(ROM_WAIT);
            state <= rpm_pkg::RPM_ROM_RD;
          end else if (rom_wr_go) begin
            mwr <= 1'b1;
            cnt <= 8'(ROM_WAIT);
            state <= rpm_pkg::RPM_ROM_WR;
          end
        end
        rpm_pkg::RPM_LD_CS: begin
          ld_cs <= 1'b1;
          ld_clk <= 1'b0;
          bitn <= 5'h00;
          cnt <= 8'(LOAD_HALF);
          state <= rpm_pkg::RPM_LD_SHIFT;
        end
        rpm_pkg::RPM_LD_SHIFT: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            cnt <= 8'(LOAD_HALF);
            ld_clk <= !ld_clk;
            if (ld_clk) begin
              shreg <= {shreg[14:0], sdo_s2};
              bitn <= bitn + 5'h01;
              if (bitn == 5'(`RPM_LOAD_BITS - 1)) begin
                state <= rpm_pkg::RPM_LD_NEXT;
              end
            end
          end
        end
        rpm_pkg::RPM_LD_NEXT: begin
          ld_cs <= 1'b0;
          ld_clk <= 1'b0;
          word <= word + 5'h01;
          if (word == 5'(`RPM_LOAD_WORDS - 1)) begin
            state <= rpm_pkg::RPM_IDLE;
          end else begin
            state <= rpm_pkg::RPM_LD_CS;
          end
        end
        rpm_pkg::RPM_ROM_RD, rpm_pkg::RPM_ROM_WR: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            mrd <= 1'b0;
            mwr <= 1'b0;
            state <= rpm_pkg::RPM_IDLE;
          end
        end
        default: begin
          state <= rpm_pkg::RPM_IDLE;
        end
      endcase
    end
  end

  // Each assembled word is offered to the configuration logic for one cycle.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LOAD_WORD <= 16'h0000;
      LOAD_WORD_VALID <= 1'b0;
    end else begin
      LOAD_WORD_VALID <= (state == rpm_pkg::RPM_LD_NEXT);
      if (state == rpm_pkg::RPM_LD_NEXT) begin
        LOAD_WORD <= shreg;
      end
    end
  end

  // Load-done rises with the last word and falls on a reload request.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      load_done <= 1'b0;
    end else if (irq_set[`RPM_IRQ_LOAD_DONE]) begin
      load_done <= 1'b1;
    end else if (wr_acc && WDATA[`RPM_BIT_RELOAD]) begin
      load_done <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[`RPM_IRQ_LOAD_DONE] = (state == rpm_pkg::RPM_LD_NEXT) &&
                                  (word == 5'(`RPM_LOAD_WORDS - 1));
    irq_set[`RPM_IRQ_READ_DONE] = (state == rpm_pkg::RPM_ROM_RD) && (cnt == 8'h00);
    irq_set[`RPM_IRQ_WRITE_DONE] = (state == rpm_pkg::RPM_ROM_WR) && (cnt == 8'h00);
  end

  // Set wins over a simultaneous write-one clear.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~((WR && ADDR == `RPM_OFF_IRQ_STATUS) ?
                     WDATA[`RPM_IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_mask <= '0;
    end else if (WR && ADDR == `RPM_OFF_IRQ_MASK) begin
      irq_mask <= WDATA[`RPM_IRQ_W-1:0];
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // The load sequencer owns the serial ROM pins until it returns idle.
  assign MDC = mdc;
  assign MDIO_O = mgmt_data_out_drive;
  assign MDIO_OE = mdir;
  assign SROM_CS = idle ? (srom & data[`RPM_BIT_SR_CS]) : ld_cs;
  assign SROM_CLK = idle ? (srom & data[`RPM_BIT_SR_CLK]) : ld_clk;
  assign SROM_DI = idle & srom & data[`RPM_BIT_SR_DIN];
  assign BROM_ADDR = addr_ptr;
  assign BROM_CE_N = !(mrd || mwr);
  assign BROM_OE_N = !mrd;
  assign BROM_WE_N = !mwr;
  assign BROM_DATA_O = data;
  assign BROM_DATA_OE = mwr;
  assign XREG_SEL = xreg;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [31:0] acc_word;
  always_comb begin
    acc_word = 32'h00000000;
    acc_word[`RPM_BIT_LOAD_DONE] = load_done;
    acc_word[`RPM_BIT_MDIO_IN] = mdio_s2;
    acc_word[`RPM_BIT_MDIR] = mdir;
    acc_word[`RPM_BIT_MGMT_DATA_OUT_DRIVE] = mgmt_data_out_drive;
    acc_word[`RPM_BIT_MDC] = mdc;
    acc_word[`RPM_BIT_ONE_HI] = 1'b1;
    acc_word[`RPM_BIT_MRD] = mrd;
    acc_word[`RPM_BIT_MWR] = mwr;
    acc_word[`RPM_BIT_BROM] = brom;
    acc_word[`RPM_BIT_SROM] = srom;
    acc_word[`RPM_BIT_XREG] = xreg;
    acc_word[`RPM_BIT_ONE_LO_H] = 1'b1;
    acc_word[`RPM_BIT_ONE_LO_L] = 1'b1;
    acc_word[7:0] = data;
    if (srom) begin
      acc_word[`RPM_BIT_SR_DOUT] = sdo_s2;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      case (ADDR)
        `RPM_OFF_ACCESS: RDATA <= acc_word;
        `RPM_OFF_ADDRPTR: RDATA <= 32'(addr_ptr);
        `RPM_OFF_IRQ_STATUS: RDATA <= 32'(irq_status);
        `RPM_OFF_IRQ_MASK: RDATA <= 32'(irq_mask);
        `RPM_OFF_LOAD_IMAGE: RDATA <= {16'h0000, LOAD_WORD};
        default: RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule : rpm_access_port

// ### core/rpm_defs.svh
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH
`define RPM_OFF_ACCESS 8'h00
`define RPM_OFF_ADDRPTR 8'h04
`define RPM_OFF_IRQ_STATUS 8'h08
`define RPM_OFF_IRQ_MASK 8'h0C
`define RPM_OFF_LOAD_IMAGE 8'h10
`define RPM_BIT_LOAD_DONE 21
`define RPM_BIT_RELOAD 20
`define RPM_BIT_MDIO_IN 19
`define RPM_BIT_MDIR 18
`define RPM_BIT_MGMT_DATA_OUT_DRIVE 17
`define RPM_BIT_MDC 16
`define RPM_BIT_ONE_HI 15
`define RPM_BIT_MRD 14
`define RPM_BIT_MWR 13
`define RPM_BIT_BROM 12
`define RPM_BIT_SROM 11
`define RPM_BIT_XREG 10
`define RPM_BIT_ONE_LO_H 9
`define RPM_BIT_ONE_LO_L 8
`define RPM_BIT_SR_DOUT 3
`define RPM_BIT_SR_DIN 2
`define RPM_BIT_SR_CLK 1
`define RPM_BIT_SR_CS 0
`define RPM_RST_BROM 1'b1
`define RPM_RST_SROM 1'b0
`define RPM_RST_XREG 1'b1
`define RPM_RST_DATA 8'hFF
`define RPM_IRQ_LOAD_DONE 0
`define RPM_IRQ_READ_DONE 1
`define RPM_IRQ_WRITE_DONE 2
`define RPM_IRQ_W 3
`define RPM_LOAD_WORDS 16
`define RPM_LOAD_BITS 16
`endif

// ### core/rpm_pkg.sv
package rpm_pkg;
  typedef enum logic [2:0] {
    RPM_IDLE = 3'b000,
    RPM_LD_CS = 3'b001,
    RPM_LD_SHIFT = 3'b010,
    RPM_LD_NEXT = 3'b011,
    RPM_ROM_RD = 3'b100,
    RPM_ROM_WR = 3'b101
  } rpm_state_t;
endpackage : rpm_pkg

// ### verif/rpm_access_port_properties.sv
`timescale 1ns/1ps
module rpm_access_port_properties #(
  parameter int ADDR_W = 18
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic MUX_MODE,
  input wire logic MDC,
  input wire logic MDIO_I,
  input wire logic MDIO_O,
  input wire logic MDIO_OE,
  input wire logic [ADDR_W-1:0] BROM_ADDR,
  input wire logic BROM_CE_N,
  input wire logic BROM_OE_N,
  input wire logic BROM_WE_N,
  input wire logic XREG_SEL,
  input wire logic LOAD_WORD_VALID
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic acc_wr;
  assign acc_wr = WR && ADDR == 8'h00;
  property p_mdc; acc_wr |=> MDC == $past(WDATA[16]); endproperty
  property p_mdo; acc_wr |=> MDIO_O == $past(WDATA[17]); endproperty
  property p_mdir; acc_wr |=> MDIO_OE == $past(WDATA[18]); endproperty
  property p_xreg; acc_wr |=> XREG_SEL == $past(WDATA[10]); endproperty
  property p_ptr;
    WR && ADDR == 8'h04 |=> BROM_ADDR == $past(WDATA[ADDR_W-1:0]);
  endproperty
  property p_mgmt_data_in_sample;
    RD && ADDR == 8'h00 && $stable(MDIO_I) && MDIO_I == $past(MDIO_I, 2)
      && MDIO_I == $past(MDIO_I, 3) |=> RDATA[19] == $past(MDIO_I);
  endproperty
  property p_rd; !BROM_OE_N |-> !BROM_CE_N && BROM_WE_N; endproperty
  property p_wr; $fell(BROM_WE_N) |-> MUX_MODE && !BROM_CE_N; endproperty
  property p_cyc; $fell(BROM_CE_N) |-> !BROM_CE_N [*5] ##1 BROM_CE_N; endproperty
  property p_ldv; LOAD_WORD_VALID |=> !LOAD_WORD_VALID; endproperty
  a_mdc: assert property (p_mdc) else $error("MDC differs from bit 16");
  a_mdo: assert property (p_mdo) else $error("MDIO out differs from bit 17");
  a_mdir: assert property (p_mdir) else $error("MDIO enable differs from bit 18");
  a_xreg: assert property (p_xreg) else $error("XREG_SEL differs from bit 10");
  a_ptr: assert property (p_ptr) else $error("ROM address not from pointer");
  a_mgmt_data_in_sample: assert property (p_mgmt_data_in_sample) else $error("bit 19 not the MDIO level");
  a_rd: assert property (p_rd) else $error("ROM read strobe outside read");
  a_wr: assert property (p_wr) else $error("ROM write without mux mode");
  a_cyc: assert property (p_cyc) else $error("ROM cycle length wrong");
  a_ldv: assert property (p_ldv) else $error("load word pulse too long");
  c_rd: cover property (!BROM_OE_N);
  c_wr: cover property ($fell(BROM_WE_N));
  c_ld: cover property (LOAD_WORD_VALID);
endmodule : rpm_access_port_properties

bind rpm_access_port rpm_access_port_properties #(.ADDR_W(ADDR_W)) i_props (
  .CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .MUX_MODE(MUX_MODE), .MDC(MDC), .MDIO_I(MDIO_I), .MDIO_O(MDIO_O),
  .MDIO_OE(MDIO_OE), .BROM_ADDR(BROM_ADDR), .BROM_CE_N(BROM_CE_N),
  .BROM_OE_N(BROM_OE_N), .BROM_WE_N(BROM_WE_N), .XREG_SEL(XREG_SEL),
  .LOAD_WORD_VALID(LOAD_WORD_VALID));

// ### verif/rpm_far_side.sv
`timescale 1ns/1ps
module rpm_far_side (
  input wire logic clk,
  input wire logic srom_cs,
  input wire logic srom_clk,
  output logic srom_do,
  input wire logic [17:0] brom_addr,
  input wire logic brom_ce_n,
  input wire logic brom_oe_n,
  output logic [7:0] brom_data_i,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic phy_bit,
  output logic mdio_i
);
  // Words go out most significant bit first; the pattern is not symmetric,
  // so a reversed shift shows up in the loaded word.
  localparam logic [15:0] WORD = 16'hC35A;
  logic [3:0] cnt = 4'h0;
  logic tog = 1'b0;
  always_ff @(posedge clk) tog <= ~tog;
  always_ff @(posedge srom_clk) cnt <= cnt + 4'h1;
  assign srom_do = srom_cs ? WORD[4'h0 - cnt] : tog;
  assign brom_data_i = (!brom_ce_n && !brom_oe_n) ? (brom_addr[7:0] ^ 8'h5A) : {8{tog}};
  assign mdio_i = mdio_oe ? mdio_o : phy_bit;
endmodule : rpm_far_side

// ### verif/tb_rpm_access_port.sv
`timescale 1ns/1ps
module tb_rpm_access_port;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h00000000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic MUX_MODE = 1'b0;
  logic phy_bit = 1'b0;
  logic [31:0] RDATA, rv;
  logic IRQ, MDC, MDIO_I, MDIO_O, MDIO_OE, SROM_CS, SROM_CLK, SROM_DI, SROM_DO;
  logic BROM_CE_N, BROM_OE_N, BROM_WE_N, XREG_SEL, BROM_DATA_OE, LOAD_WORD_VALID;
  logic [17:0] BROM_ADDR;
  logic [7:0] BROM_DATA_I, BROM_DATA_O;
  logic [15:0] LOAD_WORD;
  int failures = 0;
  int num_checks = 0;
  int words_seen = 0;
  always @(negedge CLK) begin
    if (LOAD_WORD_VALID === 1'b1) words_seen++;
  end
  always #2 CLK = ~CLK;
  rpm_access_port #(.LOAD_HALF(3)) i_dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .MUX_MODE(MUX_MODE),
    .MDC(MDC), .MDIO_I(MDIO_I), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE), .SROM_CS(SROM_CS),
    .SROM_CLK(SROM_CLK), .SROM_DI(SROM_DI), .SROM_DO(SROM_DO), .BROM_ADDR(BROM_ADDR),
    .BROM_CE_N(BROM_CE_N), .BROM_OE_N(BROM_OE_N), .BROM_WE_N(BROM_WE_N),
    .XREG_SEL(XREG_SEL), .BROM_DATA_I(BROM_DATA_I), .BROM_DATA_O(BROM_DATA_O),
    .BROM_DATA_OE(BROM_DATA_OE), .LOAD_WORD(LOAD_WORD), .LOAD_WORD_VALID(LOAD_WORD_VALID));
  rpm_far_side i_far (.clk(CLK), .srom_cs(SROM_CS), .srom_clk(SROM_CLK),
    .srom_do(SROM_DO), .brom_addr(BROM_ADDR), .brom_ce_n(BROM_CE_N),
    .brom_oe_n(BROM_OE_N), .brom_data_i(BROM_DATA_I), .mdio_o(MDIO_O),
    .mdio_oe(MDIO_OE), .phy_bit(phy_bit), .mdio_i(MDIO_I));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd
  task automatic wait_load();
    for (int i = 0; i < 3000; i++) begin
      rd(8'h00, rv);
      if (rv[21] === 1'b1) break;
    end
    chk(rv[21], 1'b1);
    chk(LOAD_WORD, 16'hC35A);
  endtask : wait_load
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_load();
    rd(8'h00, rv);
    chk(rv, 32'h000097FF);
    wait_load();
    chk(words_seen, 16);
    rd(8'h10, rv);
    chk(rv, 32'h0000C35A);
    rd(8'h08, rv);
    chk(rv[0], 1'b1);
    chk(IRQ, 1'b0);
    wr(8'h0C, 32'h00000007);
    chk(IRQ, 1'b1);
    rd(8'h0C, rv);
    chk(rv, 32'h00000007);
    wr(8'h08, 32'h00000001);
    chk(IRQ, 1'b0);
    wr(8'h00, 32'h00101400);
    rd(8'h00, rv);
    chk(rv[21], 1'b0);
    wait_load();
    chk(words_seen, 32);
    wr(8'h08, 32'h00000001);
  endtask : t_load
  task automatic t_mii();
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {13'h0000, i[2:0], 16'h1400});
      chk(MDC, i[0]);
      chk(MDIO_O, i[1]);
      chk(MDIO_OE, i[2]);
    end
    chk(XREG_SEL, 1'b1);
    for (int b = 1; b >= 0; b--) begin
      wr(8'h00, 32'h00001400);
      phy_bit <= b[0];
      repeat (4) @(posedge CLK);
      rd(8'h00, rv);
      chk(rv[19], b[0]);
    end
  endtask : t_mii
  task automatic t_srom();
    wr(8'h00, 32'h00000807);
    chk({SROM_CS, SROM_CLK, SROM_DI}, 3'b111);
    chk(XREG_SEL, 1'b0);
    wr(8'h00, 32'h00000802);
    chk({SROM_CS, SROM_CLK, SROM_DI}, 3'b010);
    wr(8'h00, 32'h00000801);
    repeat (4) @(posedge CLK);
    rd(8'h00, rv);
    chk(rv[3], SROM_DO);
    wr(8'h00, 32'h00001407);
    chk({SROM_CS, SROM_CLK, SROM_DI}, 3'b000);
  endtask : t_srom
  task automatic t_brom();
    wr(8'h04, 32'h00020033);
    rd(8'h04, rv);
    chk(rv, 32'h00020033);
    chk(BROM_ADDR, 18'h20033);
    wr(8'h00, 32'h00005400);
    chk({BROM_CE_N, BROM_OE_N, BROM_WE_N}, 3'b001);
    repeat (10) @(posedge CLK);
    rd(8'h00, rv);
    chk(rv[7:0], 8'h69);
    wr(8'h00, 32'h0000343C);
    repeat (10) @(posedge CLK);
    rd(8'h08, rv);
    chk(rv[2:1], 2'b01);
    @(posedge CLK);
    MUX_MODE <= 1'b1;
    repeat (2) @(posedge CLK);
    wr(8'h00, 32'h0000343C);
    for (int i = 0; i < 20 && BROM_WE_N !== 1'b0; i++) @(posedge CLK);
    chk({BROM_WE_N, BROM_DATA_OE, BROM_DATA_O}, 10'h13C);
    repeat (10) @(posedge CLK);
    rd(8'h08, rv);
    chk(rv[2], 1'b1);
    rd(8'h40, rv);
    chk(rv, 32'h00000000);
  endtask : t_brom
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge CLK);
    ARST_N <= 1'b1;
    t_load();
    t_mii();
    t_srom();
    t_brom();
    wrap_up();
  end
endmodule : tb_rpm_access_port
